//--- verilog/tpw_defines.vh
`ifndef TPW_DEFINES_VH
`define TPW_DEFINES_VH

// Register offsets on the control port
`define TPW_OFF_TEMPLATE   8'h06
`define TPW_OFF_SCALE      8'h07
`define TPW_OFF_ACCESS     8'h08
`define TPW_OFF_SAMPLE     8'h09
`define TPW_OFF_INT_MASK   8'h15
`define TPW_OFF_INT_STAT   8'h1A

// Access control field positions
`define TPW_SUB_LSB        0
`define TPW_SUB_MSB        3
`define TPW_UI_LSB         4
`define TPW_UI_MSB         5
`define TPW_DIR_BIT        6
`define TPW_GO_BIT         7

// Sample field positions
`define TPW_SIGN_BIT       6
`define TPW_MAG_MSB        5

// Overflow bit in mask and status registers
`define TPW_OVF_BIT        0

// Template codes and reset values
`define TPW_TPL_E1_75      4'h0
`define TPW_TPL_E1_120     4'h1
`define TPW_TPL_T1_SHORT   4'h2
`define TPW_TPL_RESET      4'h0
`define TPW_SCALE_E1       6'h21
`define TPW_SCALE_T1       6'h36
`define TPW_MAG_MAX        9'h03F

// System clock cycles per sub-phase enable
`define TPW_SUB_DIV        8

`endif

//--- verilog/tpw_waveform.v
// Functional notes
// - template code 11xx selects arbitrary waveform
// - pulse spans four intervals, two-bit index
// - sixteen sub-phases per interval, four-bit index
// - samples are signed magnitude, +63 to -63
// - waveform RAM holds sixty-four samples
// - three preset templates kept in ROM, other non-11xx codes load zeros
// - sample register carries RAM write/read data
// - direction zero writes, one reads
// - go bit runs the addressed RAM access
// - summed overlap beyond limit sets overflow
// - masked overflow flag raises interrupt
// - scaling applies only in arbitrary mode
// - E1 scale default 100001, 3% step
// - short T1 scale default 110110, 2% step
// - long haul picks one of four grades
`timescale 1ns/10ps
`include "tpw_defines.vh"
module tpw_waveform #(
  parameter SUB_DIV = `TPW_SUB_DIV
) (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  input  wire       tx_mark_i,
  input  wire       tx_neg_i,
  output wire       sub_tick_o,
  output reg  [9:0] line_amp_o,
  output wire       long_haul_o,
  output wire [1:0] lbo_grade_o,
  output wire       int_o
);

  // Control and status state
  reg  [3:0] pulse_template_select;
  reg  [5:0] amplitude_scale_code;
  reg  [3:0] sub_phase_index;
  reg  [1:0] unit_interval_index;
  reg        access_dir;
  reg        access_go;
  reg  [6:0] sample_amplitude;
  reg        overflow_interrupt_mask;
  reg        overflow_status_flag;
  reg        scale_ref_e1;
  reg  [6:0] ram [0:63];
  reg        copy_active;
  reg  [5:0] copy_idx;
  reg  [3:0] copy_tpl;
  reg  [7:0] div_cnt;
  reg  [3:0] phase_cnt;
  reg  [3:0] hist_mark;
  reg  [3:0] hist_neg;
  reg        mark_meta;
  reg        mark_sync;
  reg        neg_meta;
  reg        neg_sync;
  reg signed [10:0] sum;
  reg signed [17:0] scaled;
  integer k;

  // Preset sample store; template tables not carried here load zeros
  function [6:0] tpw_rom;
    input [3:0] tpl;
    input [5:0] idx;
    begin
      tpw_rom = 7'h00;
      case (tpl)
        `TPW_TPL_E1_75: begin
          if (idx == 6'h03)
            tpw_rom = 7'h0C;
          else if (idx >= 6'h04 && idx <= 6'h0B)
            tpw_rom = 7'h30;
        end
        `TPW_TPL_E1_120: begin
          if (idx == 6'h03)
            tpw_rom = 7'h0F;
          else if (idx >= 6'h04 && idx <= 6'h0B)
            tpw_rom = 7'h3C;
        end
        `TPW_TPL_T1_SHORT: begin
          case (idx)
            6'h00: tpw_rom = 7'h17;
            6'h01: tpw_rom = 7'h27;
            6'h02: tpw_rom = 7'h27;
            6'h03: tpw_rom = 7'h26;
            6'h04: tpw_rom = 7'h25;
            6'h05: tpw_rom = 7'h25;
            6'h06: tpw_rom = 7'h25;
            6'h07: tpw_rom = 7'h24;
            6'h08: tpw_rom = 7'h23;
            6'h09: tpw_rom = 7'h4A;
            6'h0A: tpw_rom = 7'h4A;
            6'h0B: tpw_rom = 7'h49;
            6'h0C: tpw_rom = 7'h47;
            6'h0D: tpw_rom = 7'h45;
            6'h0E: tpw_rom = 7'h44;
            6'h0F: tpw_rom = 7'h43;
            6'h10: tpw_rom = 7'h42;
            6'h11: tpw_rom = 7'h41;
            default: tpw_rom = 7'h00;
          endcase
        end
        default: tpw_rom = 7'h00;
      endcase
    end
  endfunction

  // Signed-magnitude sample to two's complement, flipped for negative marks
  function signed [10:0] tpw_amp;
    input [6:0] s;
    input       neg;
    begin
      if (s[`TPW_SIGN_BIT] ^ neg)
        tpw_amp = -$signed({5'h00, s[`TPW_MAG_MSB:0]});
      else
        tpw_amp = $signed({5'h00, s[`TPW_MAG_MSB:0]});
    end
  endfunction

  wire arb_mode = (pulse_template_select[3:2] == 2'b11);
  wire lh_mode  = (pulse_template_select[3:2] == 2'b10);
  wire wr_tpl   = reg_wr_i && (reg_addr_i == `TPW_OFF_TEMPLATE);
  wire wr_acc   = reg_wr_i && (reg_addr_i == `TPW_OFF_ACCESS);
  wire wr_smp   = reg_wr_i && (reg_addr_i == `TPW_OFF_SAMPLE);
  wire rd_stat  = reg_rd_i && (reg_addr_i == `TPW_OFF_INT_STAT);
  wire [5:0] acc_idx = {unit_interval_index, sub_phase_index};
  wire do_access = access_go && !copy_active;
  wire phase_tick = (div_cnt == SUB_DIV[7:0] - 8'h01);
  wire ovf_event = phase_tick &&
                   ((sum > $signed({2'b00, `TPW_MAG_MAX})) ||
                    (sum < -$signed({2'b00, `TPW_MAG_MAX})));

  assign sub_tick_o  = phase_tick;
  assign long_haul_o = lh_mode;
  assign lbo_grade_o = pulse_template_select[1:0];
  assign int_o = overflow_status_flag & overflow_interrupt_mask;

  // Register writes and indirect RAM access sequencing
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      pulse_template_select   <= `TPW_TPL_RESET;
      amplitude_scale_code    <= `TPW_SCALE_E1;
      scale_ref_e1            <= 1'b1;
      sub_phase_index         <= 4'h0;
      unit_interval_index     <= 2'h0;
      access_dir              <= 1'b0;
      access_go               <= 1'b0;
      sample_amplitude        <= 7'h00;
      overflow_interrupt_mask <= 1'b0;
      copy_active             <= 1'b1;
      copy_idx                <= 6'h00;
      copy_tpl                <= `TPW_TPL_RESET;
    end else begin
      if (wr_tpl) begin
        pulse_template_select <= reg_wdata_i[3:0];
        // Preset picked: reload RAM as a starting point and set its scale
        if (reg_wdata_i[3:2] != 2'b11) begin
          copy_active <= 1'b1;
          copy_idx    <= 6'h00;
          copy_tpl    <= reg_wdata_i[3:0];
          if (reg_wdata_i[3:1] == 3'b000) begin
            amplitude_scale_code <= `TPW_SCALE_E1;
            scale_ref_e1         <= 1'b1;
          end else begin
            amplitude_scale_code <= `TPW_SCALE_T1;
            scale_ref_e1         <= 1'b0;
          end
        end
      end else if (copy_active) begin
        copy_idx <= copy_idx + 6'h01;
        if (copy_idx == 6'h3F)
          copy_active <= 1'b0;
      end
      if (reg_wr_i && reg_addr_i == `TPW_OFF_SCALE)
        amplitude_scale_code <= reg_wdata_i[5:0];
      if (reg_wr_i && reg_addr_i == `TPW_OFF_INT_MASK)
        overflow_interrupt_mask <= reg_wdata_i[`TPW_OVF_BIT];
      // Go held pending while a ROM reload owns the RAM
      if (wr_acc) begin
        sub_phase_index     <= reg_wdata_i[`TPW_SUB_MSB:`TPW_SUB_LSB];
        unit_interval_index <= reg_wdata_i[`TPW_UI_MSB:`TPW_UI_LSB];
        access_dir          <= reg_wdata_i[`TPW_DIR_BIT];
        access_go           <= reg_wdata_i[`TPW_GO_BIT];
      end else if (do_access) begin
        access_go <= 1'b0;
      end
      if (wr_smp)
        sample_amplitude <= reg_wdata_i[6:0];
      else if (do_access && access_dir && !wr_acc)
        sample_amplitude <= ram[acc_idx];
    end
  end

  // RAM writes from the ROM reload or a software write access
  always @(posedge clk_i) begin
    if (copy_active && !wr_tpl)
      ram[copy_idx] <= tpw_rom(copy_tpl, copy_idx);
    else if (do_access && !access_dir && !wr_acc)
      ram[acc_idx] <= sample_amplitude;
  end

  // Two-flop sync; encoder levels come from the transmit clock
  // Limitation: mark and polarity must settle well before the UI ends,
  // since each bit crosses on its own and only one sample per UI is used
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      mark_meta <= 1'b0;
      mark_sync <= 1'b0;
      neg_meta  <= 1'b0;
      neg_sync  <= 1'b0;
    end else begin
      mark_meta <= tx_mark_i;
      mark_sync <= mark_meta;
      neg_meta  <= tx_neg_i;
      neg_sync  <= neg_meta;
    end
  end

  // Sub-phase divider and history of the last four marks
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      div_cnt   <= 8'h00;
      phase_cnt <= 4'h0;
      hist_mark <= 4'h0;
      hist_neg  <= 4'h0;
    end else if (phase_tick) begin
      div_cnt   <= 8'h00;
      phase_cnt <= phase_cnt + 4'h1;
      // New interval starts; older pulses move one UI further on
      if (phase_cnt == 4'hF) begin
        hist_mark <= {hist_mark[2:0], mark_sync};
        hist_neg  <= {hist_neg[2:0], neg_sync};
      end
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // Overlap sum: pulse k contributes its UI k sample at this sub-phase
  always @* begin
    sum = 11'sd0;
    for (k = 0; k < 4; k = k + 1) begin
      if (hist_mark[k])
        sum = sum + tpw_amp(ram[{k[1:0], phase_cnt}], hist_neg[k]);
    end
  end

  // Ratio to the reference code keeps steps near 3% for E1, 2% for T1
  always @* begin
    scaled = sum * $signed({1'b0, amplitude_scale_code});
    if (scale_ref_e1)
      scaled = scaled / 18'sd33;
    else
      scaled = scaled / 18'sd54;
  end

  // Line amplitude; presets and build-out pass unscaled
  always @(posedge clk_i) begin
    if (!resetn_i)
      line_amp_o <= 10'h000;
    else if (phase_tick) begin
      if (arb_mode)
        line_amp_o <= scaled[9:0];
      else
        line_amp_o <= sum[9:0];
    end
  end

  // Sticky overflow; a new event wins over the clear-on-read
  always @(posedge clk_i) begin
    if (!resetn_i)
      overflow_status_flag <= 1'b0;
    else if (ovf_event)
      overflow_status_flag <= 1'b1;
    else if (rd_stat)
      overflow_status_flag <= 1'b0;
  end

  // Register read data, registered; unmapped offsets read zero
  always @(posedge clk_i) begin
    if (!resetn_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i) begin
      case (reg_addr_i)
        `TPW_OFF_TEMPLATE: reg_rdata_o <= {4'h0, pulse_template_select};
        `TPW_OFF_SCALE:    reg_rdata_o <= {2'b00, amplitude_scale_code};
        `TPW_OFF_ACCESS:   reg_rdata_o <= {access_go, access_dir,
                                           unit_interval_index,
                                           sub_phase_index};
        `TPW_OFF_SAMPLE:   reg_rdata_o <= {1'b0, sample_amplitude};
        `TPW_OFF_INT_MASK: reg_rdata_o <= {7'h00, overflow_interrupt_mask};
        `TPW_OFF_INT_STAT: reg_rdata_o <= {7'h00, overflow_status_flag};
        default:           reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

//--- testbench/tpw_waveform_checker.sv
`timescale 1ns/10ps
module tpw_waveform_checker #(
  parameter int SUB_DIV = 8
) (
  input wire       clk_i,
  input wire       resetn_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire       tx_mark_i,
  input wire       tx_neg_i,
  input wire       sub_tick_o,
  input wire [9:0] line_amp_o,
  input wire       long_haul_o,
  input wire [1:0] lbo_grade_o,
  input wire       int_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Template writes, decoded once for the mode checks
  wire tpl_wr = reg_wr_i && reg_addr_i == 8'h06;

  // Reset must clear outputs even while reset is still held
  rst_clear_a: assert property (disable iff (1'b0) !resetn_i |=>
    reg_rdata_o == 8'h00 && line_amp_o == 10'h000 && !int_o && !long_haul_o)
    else $error("outputs not cleared by reset");
  tick_period_a: assert property (sub_tick_o |-> ##SUB_DIV sub_tick_o)
    else $error("sub-phase tick period wrong");
  tick_gap_a: assert property (sub_tick_o |=> !sub_tick_o)
    else $error("sub-phase tick longer than one cycle");
  amp_hold_a: assert property (!sub_tick_o |=> $stable(line_amp_o))
    else $error("line amplitude moved between ticks");
  grade_sel_a: assert property (tpl_wr && reg_wdata_i[3:2] == 2'b10 |=>
    long_haul_o && lbo_grade_o == $past(reg_wdata_i[1:0]))
    else $error("build-out grade not taken");
  arb_mode_a: assert property (tpl_wr && reg_wdata_i[3:2] == 2'b11 |=>
    !long_haul_o) else $error("arbitrary code left build-out on");
  mask_off_a: assert property (reg_wr_i && reg_addr_i == 8'h15 &&
    !reg_wdata_i[0] |=> !int_o) else $error("masked overflow interrupts");
  unmapped_a: assert property (reg_rd_i && !(reg_addr_i inside {8'h06,
    8'h07, 8'h08, 8'h09, 8'h15, 8'h1A}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  cover property (tpl_wr && reg_wdata_i[3:2] == 2'b11);
  cover property ($rose(int_o));
  cover property (reg_rd_i && reg_addr_i == 8'h1A);
endmodule
bind tpw_waveform tpw_waveform_checker #(.SUB_DIV(SUB_DIV)) u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .tx_mark_i(tx_mark_i), .tx_neg_i(tx_neg_i),
  .sub_tick_o(sub_tick_o), .line_amp_o(line_amp_o),
  .long_haul_o(long_haul_o), .lbo_grade_o(lbo_grade_o), .int_o(int_o));

//--- testbench/transmit_pulse_waveform_ram_test.sv
`timescale 1ns/10ps
module transmit_pulse_waveform_ram_test;
  localparam SUB_DIV = 2; // Short sub-phase keeps overflow runs brief
  reg        clk_i, resetn_i, reg_wr_i, reg_rd_i, tx_mark_i, tx_neg_i;
  reg  [7:0] reg_addr_i, reg_wdata_i;
  wire [7:0] reg_rdata_o;
  wire [9:0] line_amp_o;
  wire [1:0] lbo_grade_o;
  wire       sub_tick_o, long_haul_o, int_o;
  reg [31:0] rng;
  reg  [6:0] smp [0:63];
  reg [15:0] note_q [$];
  reg        rd_seen;
  reg        tick_seen;
  reg [10:0] amp_q [$];
  integer    err_total, n_tests, cyc, i;
  tpw_waveform #(.SUB_DIV(SUB_DIV)) u_dut (.clk_i(clk_i),
    .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tx_mark_i(tx_mark_i), .tx_neg_i(tx_neg_i), .sub_tick_o(sub_tick_o),
    .line_amp_o(line_amp_o), .long_haul_o(long_haul_o),
    .lbo_grade_o(lbo_grade_o), .int_o(int_o));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  function [31:0] xs(input [31:0] v);
    reg [31:0] x;
    begin
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // Strobes stay up across back-to-back calls, never reassigned in a step
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_rd_i = 1'b0; reg_addr_i = a; reg_wdata_i = d; reg_wr_i = 1'b1;
      @(negedge clk_i);
    end
  endtask
  task rd(input [7:0] a, input [7:0] e, input [7:0] m);
    begin
      note_q.push_back({m, e});
      reg_wr_i = 1'b0; reg_addr_i = a; reg_rd_i = 1'b1;
      @(negedge clk_i);
    end
  endtask
  task idle(input integer n);
    begin
      reg_wr_i = 1'b0; reg_rd_i = 1'b0;
      repeat (n) @(negedge clk_i);
    end
  endtask
  task ram_wr(input [5:0] idx, input [6:0] d);
    begin
      wr(8'h09, {1'b0, d});
      wr(8'h08, {2'b10, idx});
      idle(3);
    end
  endtask
  task ram_rd(input [5:0] idx);
    begin
      wr(8'h08, {2'b11, idx});
      idle(3);
      rd(8'h09, {1'b0, smp[idx]}, 8'hFF);
      rd(8'h08, 8'h00, 8'h80);
    end
  endtask
  task chk(input [15:0] n);
    begin
      n_tests = n_tests + 1;
      if ((reg_rdata_o & n[15:8]) !== n[7:0]) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t exp=%h got=%h", $time, n[7:0], reg_rdata_o);
      end
    end
  endtask
  // Interrupt level and line amplitude judged together
  task chk_amp(input [10:0] n);
    begin
      n_tests = n_tests + 1;
      if ({int_o, line_amp_o} !== n) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t exp=%h got=%h", $time, n, {int_o, line_amp_o});
      end
    end
  endtask
  task results;
    begin
      $display("checks=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Read data lands one edge after the strobe; judge it half a cycle later
  always @(posedge clk_i) rd_seen <= reg_rd_i && resetn_i;
  always @(negedge clk_i) if (rd_seen) chk(note_q.pop_front());
  // Line notes are judged after a tick, once the new amplitude stands
  always @(posedge clk_i) tick_seen <= sub_tick_o && resetn_i;
  always @(negedge clk_i)
    if (tick_seen && amp_q.size() != 0) chk_amp(amp_q.pop_front());
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      results;
    end
  end
  initial begin
    resetn_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
    tx_mark_i = 1'b0; tx_neg_i = 1'b0; reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00; rng = 32'hA740;
    err_total = 0; n_tests = 0; cyc = 0;
    repeat (4) @(negedge clk_i);
    resetn_i = 1'b1;
    rd(8'h06, 8'h00, 8'h0F);
    rd(8'h07, 8'h21, 8'h3F);
    rd(8'h3C, 8'h00, 8'hFF);
    idle(70);
    wr(8'h06, 8'h02);
    rd(8'h07, 8'h36, 8'h3F);
    wr(8'h06, 8'h07);
    rd(8'h06, 8'h07, 8'h0F);
    rd(8'h07, 8'h36, 8'h3F);
    for (i = 0; i < 4; i = i + 1) wr(8'h06, {6'h02, i[1:0]});
    idle(70);
    rng = xs(rng);
    wr(8'h06, {6'h03, rng[1:0]});
    for (i = 0; i < 64; i = i + 1) begin
      rng = xs(rng);
      smp[i] = rng[6:0];
      tx_neg_i = rng[7];
      ram_wr(i[5:0], smp[i]);
    end
    for (i = 0; i < 64; i = i + 1) ram_rd(i[5:0]);
    // Full-scale samples in every interval so overlapping pulses overflow
    for (i = 0; i < 64; i = i + 1) ram_wr(i[5:0], 7'h3F);
    wr(8'h15, 8'h01);
    wr(8'h07, 8'h36);
    tx_neg_i = 1'b0;
    tx_mark_i = 1'b1;
    idle(6 * 16 * SUB_DIV);
    // Four overlapping +63 pulses sum to 252; code 110110 is unity for T1
    amp_q.push_back({1'b1, 10'h0FC});
    idle(2 * SUB_DIV);
    // Half the reference code halves the line amplitude
    wr(8'h07, 8'h1B);
    idle(2 * SUB_DIV);
    amp_q.push_back({1'b1, 10'h07E});
    idle(2 * SUB_DIV);
    rd(8'h1A, 8'h01, 8'h01);
    tx_mark_i = 1'b0;
    idle(6 * 16 * SUB_DIV);
    // Draining pulses overflow again before the line falls quiet
    rd(8'h1A, 8'h01, 8'h01);
    rd(8'h1A, 8'h00, 8'h01);
    amp_q.push_back({1'b0, 10'h000});
    idle(2 * SUB_DIV);
    wr(8'h15, 8'h00);
    idle(4);
    results;
  end
endmodule
